// ---- verilog/psr_regs.sv ----
// Status flags, proximity result bank and soft reset behind a serial register port.
`timescale 1ns/100ps
module psr_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter logic [7:0] REVISION_CODE = 8'h13, // Arbitrary value.
    parameter logic [7:0] DEVICE_TYPE_CODE = 8'h5c, // Arbitrary value.
    parameter logic [7:0] VERSION_CODE = 8'h07 // Arbitrary value.
) (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Serial bus pins.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Front end and configuration.
    input wire psr_pkg::psr_meas_t meas,
    input wire psr_pkg::psr_cfg_t cfg,
    // Status to the rest of the device.
    output logic [7:0] event_flags,
    output logic [6:0] pulse_count,
    output logic osc_enable
);
    import psr_pkg::*;

    // Pulse-scaled result; a zero pulse count is treated as one.
    function automatic logic [13:0] scale_result(input logic [9:0] adc, input logic [6:0] pulses);
        logic [13:0] num;
        logic [6:0] den;
        num = {adc, 4'h0};
        den = (pulses == 7'h00) ? PULSE_MIN : pulses;
        return num / {7'h00, den};
    endfunction

    logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
    logic scl_rise, scl_fall, bus_start, bus_stop;
    psr_state_t state_reg;
    logic [3:0] cnt_reg;
    logic [7:0] shift_reg, ptr_reg, rd_data, wdata;
    logic rw_reg, first_reg, rd_stb, wr_stb, soft_hit, rst_any;
    logic [7:0] flags_reg, flags_next, flag_set, flag_clr, soft_ctrl_reg;
    logic [7:0] res_low_reg, res_high_reg, high_shadow_reg;
    logic [13:0] scaled;
    logic [7:0] cmp_val;
    logic val_above, val_below, evt_hit, sat_seen_reg, soft_sleep_reg, pon_q;
    logic [3:0] persist_reg, persist_next;
    logic [6:0] pulse_reg;
    logic sda_out_reg, sda_oe_reg, osc_reg, sai_halt;

    // Two-stage synchronisers on the pins, plus a third stage for edge finding.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
        end
    end

    // Bus conditions seen on the synchronised lines.
    assign scl_rise = scl_s2 & ~scl_s3;
    assign scl_fall = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
    assign wdata = shift_reg;

    // Register accesses: a read happens when a byte is loaded for sending.
    assign rd_stb = scl_fall & ((state_reg == ST_ACK & rw_reg) | state_reg == ST_RACK);
    assign wr_stb = scl_fall & state_reg == ST_WDATA & cnt_reg == BYTE_BITS;
    assign soft_hit = wr_stb & ptr_reg == REG_SOFT_RESET & wdata[SOFT_RESET_BIT];
    assign rst_any = reset | soft_hit;

    // Serial slave engine: address, pointer, write bytes and read bytes.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            cnt_reg <= 4'h0;
            sda_oe_reg <= 1'b0;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s2};
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (scl_fall && cnt_reg == BYTE_BITS) begin
                        state_reg <= ST_ACK;
                        sda_oe_reg <= 1'b1;
                        if (state_reg == ST_ADDR) begin
                            rw_reg <= shift_reg[0];
                            first_reg <= 1'b1;
                            if (shift_reg[7:1] != DEV_ADDR) begin
                                state_reg <= ST_IDLE;
                                sda_oe_reg <= 1'b0;
                            end
                        end else begin
                            first_reg <= 1'b0;
                            if (state_reg == ST_PTR) begin
                                ptr_reg <= shift_reg;
                            end else begin
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_reg <= 4'h0;
                        sda_oe_reg <= 1'b0;
                        if (rw_reg) begin
                            state_reg <= ST_READ;
                            shift_reg <= rd_data;
                            sda_oe_reg <= ~rd_data[7];
                            ptr_reg <= ptr_reg + 8'h01;
                        end else begin
                            state_reg <= first_reg ? ST_PTR : ST_WDATA;
                        end
                    end
                end
                ST_READ: begin
                    if (scl_fall) begin
                        if (cnt_reg == LAST_BIT) begin
                            state_reg <= ST_RACK;
                            sda_oe_reg <= 1'b0;
                        end else begin
                            sda_oe_reg <= ~shift_reg[6];
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            cnt_reg <= cnt_reg + 4'h1;
                        end
                    end
                end
                ST_RACK: begin
                    if (scl_rise && sda_s2) begin
                        state_reg <= ST_IDLE;
                    end else if (scl_fall) begin
                        state_reg <= ST_READ;
                        cnt_reg <= 4'h0;
                        shift_reg <= rd_data;
                        sda_oe_reg <= ~rd_data[7];
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Read data selection; unmapped addresses read as zero.
    always_comb begin
        case (ptr_reg)
            REG_REVISION: rd_data = REVISION_CODE;
            REG_DEVTYPE: rd_data = DEVICE_TYPE_CODE;
            REG_FLAGS: rd_data = flags_reg;
            REG_RES_LOW: rd_data = res_low_reg;
            REG_RES_HIGH: rd_data = high_shadow_reg;
            REG_VERSION: rd_data = VERSION_CODE;
            REG_SOFT_RESET: rd_data = soft_ctrl_reg;
            default: rd_data = 8'h00;
        endcase
    end

    // Threshold comparison and persistence filtering of each measurement.
    always_comb begin
        scaled = scale_result(meas.adc, meas.pulses);
        cmp_val = cfg.apc_disable ? meas.adc[9:2] : scaled[13:6];
        val_above = cmp_val > cfg.high_threshold_byte;
        val_below = cmp_val < cfg.low_threshold_byte;
        persist_next = 4'h0;
        if (val_above || val_below) begin
            persist_next = (persist_reg == 4'hf) ? persist_reg : persist_reg + 4'h1;
        end
        evt_hit = meas.done & (val_above | val_below) & (persist_next >= cfg.persist);
    end

    // Flag set and clear terms; a set in the same cycle beats a clear.
    always_comb begin
        flag_set = 8'h00;
        flag_set[FLG_EVENT] = evt_hit;
        flag_set[FLG_ABOVE] = evt_hit & val_above;
        flag_set[FLG_BELOW] = evt_hit & val_below;
        flag_set[FLG_SAT] = meas.done & (sat_seen_reg | meas.ambient_sat | meas.reflect_sat);
        flag_set[FLG_CALIB] = meas.calib_done;
        flag_set[FLG_ZERO] = meas.zero_detect & cfg.auto_offset_trim;
        flag_set[FLG_REFLECT] = meas.reflect_sat;
        flag_set[FLG_AMBIENT] = meas.ambient_sat;
        flag_clr = (wr_stb && ptr_reg == REG_FLAGS) ? wdata : 8'h00;
        if (rd_stb && ptr_reg == REG_FLAGS && cfg.read_clear) begin
            flag_clr = 8'hff;
        end
        flags_next = (flags_reg & ~flag_clr) | flag_set;
        flags_next[FLG_ABOVE] = flags_next[FLG_ABOVE] & flags_next[FLG_EVENT];
        flags_next[FLG_BELOW] = flags_next[FLG_BELOW] & flags_next[FLG_EVENT];
    end

    // Flag register, persistence count and saturation memory.
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            flags_reg <= FLAGS_RESET;
            persist_reg <= PERSIST_RESET;
            sat_seen_reg <= 1'b0;
        end else begin
            flags_reg <= flags_next;
            if (meas.done) begin
                persist_reg <= persist_next;
                sat_seen_reg <= 1'b0;
            end else if (meas.ambient_sat || meas.reflect_sat) begin
                sat_seen_reg <= 1'b1;
            end
        end
    end

    // Result bytes and the high byte latched by a low byte read.
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            res_low_reg <= RESULT_RESET;
            res_high_reg <= RESULT_RESET;
            high_shadow_reg <= RESULT_RESET;
        end else begin
            if (meas.done && cfg.apc_disable) begin
                res_low_reg <= meas.adc[9:2];
                res_high_reg <= {6'h00, meas.adc[1:0]};
            end else if (meas.done) begin
                res_low_reg <= scaled[7:0];
                res_high_reg <= {2'h0, scaled[13:8]};
            end
            if (rd_stb && ptr_reg == REG_RES_LOW) begin
                high_shadow_reg <= res_high_reg;
            end
        end
    end

    // Pulse count for the next measurement; strong signal halves it.
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            pulse_reg <= PULSE_RESET;
        end else if (meas.done) begin
            if (cfg.apc_disable) begin
                pulse_reg <= cfg.max_pulses;
            end else if (meas.adc >= NEAR_SAT) begin
                pulse_reg <= (pulse_reg > PULSE_MIN) ? (pulse_reg >> 1) : PULSE_MIN;
            end else if (meas.adc < LOW_SIGNAL && pulse_reg < cfg.max_pulses) begin
                pulse_reg <= pulse_reg + 7'h01;
            end
        end
    end

    // Soft reset control register; its own bit returns to default at once.
    always_ff @(posedge clk_sys) begin
        if (rst_any) begin
            soft_ctrl_reg <= SOFT_CTRL_RESET;
        end else if (wr_stb && ptr_reg == REG_SOFT_RESET) begin
            soft_ctrl_reg <= wdata;
        end
    end

    // Oscillator control: soft sleep until power-on rises, halt after event.
    assign sai_halt = cfg.sleep_after_event & cfg.prox_event_enable & flags_reg[FLG_EVENT];
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            soft_sleep_reg <= 1'b0;
            pon_q <= 1'b0;
            osc_reg <= 1'b0;
        end else begin
            pon_q <= cfg.power_on_enable;
            if (soft_hit) begin
                soft_sleep_reg <= 1'b1;
            end else if (cfg.power_on_enable && !pon_q) begin
                soft_sleep_reg <= 1'b0;
            end
            osc_reg <= cfg.power_on_enable & ~soft_sleep_reg & ~sai_halt;
        end
    end

    // The data pin only ever pulls low.
    always_ff @(posedge clk_sys) begin
        sda_out_reg <= 1'b0;
    end

    assign sda_out = sda_out_reg;
    assign sda_oe = sda_oe_reg;
    assign event_flags = flags_reg;
    assign pulse_count = pulse_reg;
    assign osc_enable = osc_reg;

    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic no_evt;
    assign no_evt = ~(meas.done | meas.calib_done | meas.zero_detect | meas.ambient_sat
        | meas.reflect_sat);

    property p_above_set;
        evt_hit && val_above && !soft_hit |=> flags_reg[FLG_ABOVE] && flags_reg[FLG_EVENT];
    endproperty
    a_above_set: assert property (p_above_set) else $error("Above flag not set.");
    property p_below_follows;
        $fell(flags_reg[FLG_EVENT]) |-> !flags_reg[FLG_BELOW] && !flags_reg[FLG_ABOVE];
    endproperty
    a_below_follows: assert property (p_below_follows) else $error("Level flag kept.");
    property p_sat;
        meas.done && meas.reflect_sat && !soft_hit |=> flags_reg[FLG_SAT] && flags_reg[FLG_REFLECT];
    endproperty
    a_sat: assert property (p_sat) else $error("Saturation flags not set.");
    property p_calib;
        meas.calib_done && !soft_hit |=> flags_reg[FLG_CALIB];
    endproperty
    a_calib: assert property (p_calib) else $error("Calibration flag not set.");
    property p_zero;
        meas.zero_detect && !cfg.auto_offset_trim && !flags_reg[FLG_ZERO] |=> !flags_reg[FLG_ZERO];
    endproperty
    a_zero: assert property (p_zero) else $error("Zero flag set without trim.");
    property p_w1c;
        wr_stb && ptr_reg == REG_FLAGS && wdata[FLG_CALIB] && no_evt |=> !flags_reg[FLG_CALIB];
    endproperty
    a_w1c: assert property (p_w1c) else $error("Flag not cleared by write.");
    property p_keep;
        wr_stb && ptr_reg == REG_FLAGS && !wdata[FLG_CALIB] && flags_reg[FLG_CALIB]
            |=> flags_reg[FLG_CALIB];
    endproperty
    a_keep: assert property (p_keep) else $error("Flag lost on zero write.");
    property p_cor;
        rd_stb && ptr_reg == REG_FLAGS && cfg.read_clear && no_evt |=> flags_reg == 8'h00;
    endproperty
    a_cor: assert property (p_cor) else $error("Flags not cleared on read.");
    property p_latch;
        rd_stb && ptr_reg == REG_RES_LOW && !soft_hit |=> high_shadow_reg == $past(res_high_reg);
    endproperty
    a_latch: assert property (p_latch) else $error("High byte not latched.");
    property p_soft;
        soft_hit |=> flags_reg == 8'h00 && res_low_reg == 8'h00 ##1 !osc_enable;
    endproperty
    a_soft: assert property (p_soft) else $error("Soft reset incomplete.");
    property p_noapc;
        meas.done && cfg.apc_disable && !soft_hit |=> res_low_reg == $past(meas.adc[9:2]);
    endproperty
    a_noapc: assert property (p_noapc) else $error("Ten-bit result misplaced.");

    c_soft: cover property (soft_hit);
    c_latch: cover property (rd_stb && ptr_reg == REG_RES_LOW);
    c_event: cover property (evt_hit ##1 sai_halt);
    c_cor: cover property (rd_stb && ptr_reg == REG_FLAGS && cfg.read_clear);
endmodule // psr_regs

// ---- verilog/psr_pkg.sv ----
// Shared constants, carrier structs and state codes for the proximity status and result bank.
package psr_pkg;
    // Register addresses on the serial bus.
    localparam logic [7:0] REG_REVISION = 8'h91;
    localparam logic [7:0] REG_DEVTYPE = 8'h92;
    localparam logic [7:0] REG_FLAGS = 8'h9b;
    localparam logic [7:0] REG_RES_LOW = 8'h9c;
    localparam logic [7:0] REG_RES_HIGH = 8'h9d;
    localparam logic [7:0] REG_VERSION = 8'ha6;
    localparam logic [7:0] REG_SOFT_RESET = 8'ha8;
    // Bit positions inside the event flag register and the soft reset register.
    localparam int FLG_ABOVE = 7;
    localparam int FLG_BELOW = 6;
    localparam int FLG_SAT = 5;
    localparam int FLG_EVENT = 4;
    localparam int FLG_CALIB = 3;
    localparam int FLG_ZERO = 2;
    localparam int FLG_REFLECT = 1;
    localparam int FLG_AMBIENT = 0;
    localparam int SOFT_RESET_BIT = 0;
    // Reset values and the pulse count floor.
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] SOFT_CTRL_RESET = 8'h00;
    localparam logic [6:0] PULSE_RESET = 7'h10;
    localparam logic [6:0] PULSE_MIN = 7'h01;
    localparam logic [3:0] PERSIST_RESET = 4'h0;
    // Pulse control thresholds on the raw converter value.
    localparam logic [9:0] NEAR_SAT = 10'h300;
    localparam logic [9:0] LOW_SIGNAL = 10'h100;
    // Serial engine bit counts.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // One measurement report and the asynchronous events of the front end.
    typedef struct packed {
        logic done;
        logic [9:0] adc;
        logic [6:0] pulses;
        logic ambient_sat;
        logic reflect_sat;
        logic calib_done;
        logic zero_detect;
    } psr_meas_t;

    // Configuration bits held in registers outside this bank.
    typedef struct packed {
        logic apc_disable;
        logic read_clear;
        logic sleep_after_event;
        logic prox_event_enable;
        logic power_on_enable;
        logic auto_offset_trim;
        logic [7:0] low_threshold_byte;
        logic [7:0] high_threshold_byte;
        logic [3:0] persist;
        logic [6:0] max_pulses;
    } psr_cfg_t;

    // Serial engine states.
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACK = 7'h04,
        ST_PTR = 7'h08,
        ST_WDATA = 7'h10,
        ST_READ = 7'h20,
        ST_RACK = 7'h40
    } psr_state_t;
endpackage

// ---- testbench/psr_host.sv ----
// Serial bus host model that reads and writes the register bank.
`timescale 1ns/100ps
module psr_host #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    // Bus pins; the data line is pulled up, so the host only pulls low.
    output logic scl,
    output logic sda_oe,
    input wire logic sda
);
    localparam real Q = 31.25; // Quarter of the 125 ns bus clock.

    // The bus clock stands high and the data line is released outside frames.
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    // Drives one bit while the clock is low and samples the line late in the high phase.
    task automatic bit_io(input logic b, output logic r);
        sda_oe = ~b;
        #Q scl = 1'b1;
        #(1.5 * Q) r = sda;
        #(0.5 * Q) scl = 1'b0;
        #Q;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start();
        sda_oe = 1'b0;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b1;
        #Q scl = 1'b0;
        #Q;
    endtask

    // Stop: data rises while the clock is high, then the bus idles.
    task automatic stop();
        sda_oe = 1'b1;
        #Q scl = 1'b1;
        #Q sda_oe = 1'b0;
        #(2 * Q);
    endtask

    // Moves one byte most significant bit first, then the acknowledge bit.
    task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] r,
        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r[i]);
        end
        bit_io(ack, a);
    endtask

    // Writes one register; a holds the three acknowledge bits, low meaning answered.
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] a);
        logic [7:0] r;
        start();
        xfer({ADDR, 1'b0}, 1'b1, r, a[2]);
        xfer(ptr, 1'b1, r, a[1]);
        xfer(d, 1'b1, r, a[0]);
        stop();
    endtask

    // Reads n bytes upward from ptr, so a result pair goes low byte first.
    task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] d);
        logic [7:0] r;
        logic a;
        start();
        xfer({ADDR, 1'b0}, 1'b1, r, a);
        xfer(ptr, 1'b1, r, a);
        start();
        xfer({ADDR, 1'b1}, 1'b1, r, a);
        xfer(8'hff, n == 1, d[7:0], a);
        if (n == 2) begin
            xfer(8'hff, 1'b1, d[15:8], a);
        end
        stop();
    endtask
endmodule // psr_host

// ---- testbench/tb_psr_regs.sv ----
// Self-checking bench for the proximity status and result bank.
`timescale 1ns/100ps
module tb_psr_regs;
    import psr_pkg::*;
    localparam logic [7:0] REV = 8'h5a; // Arbitrary value.
    localparam logic [7:0] DTYPE = 8'hc3; // Arbitrary value.
    localparam logic [7:0] VER = 8'h69; // Arbitrary value.
    localparam logic [7:0] PTRS [8] = '{REG_REVISION, REG_DEVTYPE, REG_VERSION, REG_FLAGS,
        REG_RES_LOW, REG_RES_HIGH, REG_SOFT_RESET, 8'h80};
    localparam logic [7:0] VALS [8] = '{REV, DTYPE, VER, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] ACC [4] = '{8'h01, 8'h03, 8'h0b, 8'h0f};
    logic clk_sys, reset, scl, host_oe, sda_out, sda_oe, osc_enable;
    psr_meas_t meas;
    psr_cfg_t cfg;
    logic [7:0] event_flags;
    logic [6:0] pulse_count;
    logic [15:0] d;
    logic [2:0] a;
    int err_count, num_checks;
    // Wired-AND data line with its pull-up.
    wire sda = (sda_oe ? sda_out : 1'b1) & ~host_oe;

    psr_regs #(.DEV_ADDR(7'h2a), .REVISION_CODE(REV), .DEVICE_TYPE_CODE(DTYPE),
        .VERSION_CODE(VER)) dut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .meas(meas), .cfg(cfg),
        .event_flags(event_flags), .pulse_count(pulse_count), .osc_enable(osc_enable));
    psr_host #(.ADDR(7'h2a)) host (.scl(scl), .sda_oe(host_oe), .sda(sda));

    // System clock at 125 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Compares a seen value with the expected one and counts both outcomes.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Reads one register over the bus and compares it.
    task automatic rchk(input string what, input logic [7:0] ptr, input logic [7:0] exp);
        host.rd(ptr, 1, d);
        check(what, d[7:0], exp);
    endtask

    // Writes one register and expects every byte to be acknowledged.
    task automatic wchk(input logic [7:0] ptr, input logic [7:0] v);
        host.wr(ptr, v, a);
        check("ack", a, 3'b000);
        @(negedge clk_sys);
    endtask

    // Delivers one measurement report for a single cycle, then lets it settle.
    task automatic measure(input logic [9:0] adc, input logic [6:0] p);
        @(negedge clk_sys);
        meas.adc = adc;
        meas.pulses = p;
        meas.done = 1'b1;
        @(negedge clk_sys);
        meas.done = 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Cuts a hang short well past the expected run time.
    initial begin
        #600000;
        err_count++;
        results();
    end

    // Main sequence of register and measurement scenarios.
    initial begin
        err_count = 0;
        num_checks = 0;
        reset = 1'b1;
        meas = '0;
        cfg = '0;
        cfg.auto_offset_trim = 1'b1;
        cfg.high_threshold_byte = 8'hff;
        cfg.max_pulses = 7'h20;
        repeat (20) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        check("pulses", pulse_count, PULSE_RESET);
        check("osc", osc_enable, 1'b0);
        for (int i = 0; i < 8; i++) begin
            rchk("reset value", PTRS[i], VALS[i]);
        end
        wchk(REG_REVISION, 8'h00);
        rchk("read only", REG_REVISION, REV);
        // Front-end events, one at a time, each landing on its own flag.
        for (int i = 0; i < 4; i++) begin
            @(negedge clk_sys);
            meas[3 - i] = 1'b1;
            @(negedge clk_sys);
            meas[3 - i] = 1'b0;
            @(negedge clk_sys);
            check("event", event_flags, ACC[i]);
        end
        measure(10'h155, 7'd4);
        check("sat", event_flags, 8'h2f);
        check("pulses", pulse_count, 7'h10);
        host.rd(REG_RES_LOW, 2, d);
        check("result", d, 16'h0554);
        wchk(REG_FLAGS, 8'h00);
        check("keep", event_flags, 8'h2f);
        wchk(REG_FLAGS, 8'h0a);
        check("w1c", event_flags, 8'h25);
        cfg.read_clear = 1'b1;
        rchk("flags", REG_FLAGS, 8'h25);
        check("read clear", event_flags, 8'h00);
        cfg.read_clear = 1'b0;
        // Threshold event, then clearing the event takes the above flag with it.
        cfg.high_threshold_byte = 8'h10;
        measure(10'h155, 7'd4);
        check("above", event_flags, 8'h90);
        wchk(REG_FLAGS, 8'h10);
        check("clear", event_flags, 8'h00);
        measure(10'h300, 7'd2);
        check("halve", pulse_count, 7'h08);
        rchk("stale", REG_RES_HIGH, 8'h05);
        rchk("low", REG_RES_LOW, 8'h00);
        rchk("high", REG_RES_HIGH, 8'h18);
        measure(10'h0ff, 7'd8);
        check("add", pulse_count, 7'h09);
        wchk(REG_FLAGS, 8'hff);
        // Pulse control off, below threshold on the upper bits, sleep after event.
        cfg.power_on_enable = 1'b1;
        repeat (3) @(negedge clk_sys);
        check("osc", osc_enable, 1'b1);
        cfg.apc_disable = 1'b1;
        cfg.sleep_after_event = 1'b1;
        cfg.prox_event_enable = 1'b1;
        cfg.low_threshold_byte = 8'hb6;
        cfg.high_threshold_byte = 8'hff;
        measure(10'h2d6, 7'd8);
        check("below", event_flags, 8'h50);
        check("fixed", pulse_count, 7'h20);
        check("sleep", osc_enable, 1'b0);
        host.rd(REG_RES_LOW, 2, d);
        check("ten bit", d, 16'h02b5);
        wchk(REG_FLAGS, 8'hff);
        check("wake", osc_enable, 1'b1);
        // Soft reset restores defaults and sleeps the device.
        cfg.sleep_after_event = 1'b0;
        measure(10'h2d6, 7'd8);
        wchk(REG_SOFT_RESET, 8'h01);
        repeat (3) @(negedge clk_sys);
        check("soft flags", event_flags, 8'h00);
        check("soft pulses", pulse_count, PULSE_RESET);
        check("soft osc", osc_enable, 1'b0);
        rchk("soft low", REG_RES_LOW, 8'h00);
        rchk("soft ctrl", REG_SOFT_RESET, 8'h00);
        // Persistence of two: the first out-of-range result raises nothing.
        cfg.persist = 4'h2;
        measure(10'h2d6, 7'd8);
        check("persist one", event_flags, 8'h00);
        measure(10'h2d6, 7'd8);
        check("persist two", event_flags, 8'h50);
        // A zero detect without offset trimming leaves the zero flag clear.
        cfg.auto_offset_trim = 1'b0;
        @(negedge clk_sys);
        meas.zero_detect = 1'b1;
        @(negedge clk_sys);
        meas.zero_detect = 1'b0;
        @(negedge clk_sys);
        check("no trim", event_flags, 8'h50);
        results();
    end
endmodule // tb_psr_regs
